/* File: hw/fifo_ring.sv */
// circular byte store with occupancy count and synchronous clear.
// assumes one clock; writes to a full store and reads of an empty one
// are refused through the ready and valid terms.
module fifo_ring (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic clear_i,
    input wire logic wr_valid_i,
    input wire logic [7:0] wr_data_i,
    output logic wr_ready_o,
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [7:0] rd_data_o,
    output logic [host_if_pkg::CNT_W-1:0] count_o
);
    localparam logic [6:0] LAST = 7'(host_if_pkg::FIFO_DEPTH - 1);
    localparam logic [6:0] FULL = 7'(host_if_pkg::FIFO_DEPTH);

    logic [7:0] mem [host_if_pkg::FIFO_DEPTH];
    logic [6:0] wr_ptr;
    logic [6:0] rd_ptr;
    logic do_wr;
    logic do_rd;

    assign wr_ready_o = count_o != FULL;
    assign rd_valid_o = count_o != 7'h00;
    assign do_wr = wr_valid_i & wr_ready_o;
    assign do_rd = rd_ready_i & rd_valid_o;
    assign rd_data_o = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr_data_i;
        end
    end

    // locations wrap from the last slot back to zero
    always_ff @(posedge clk_i) begin
        if (srst_i || clear_i) begin
            wr_ptr <= 7'h00;
            rd_ptr <= 7'h00;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == LAST) ? 7'h00 : wr_ptr + 7'h01;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == LAST) ? 7'h00 : rd_ptr + 7'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || clear_i) begin
            count_o <= 7'h00;
        end else if (do_wr && !do_rd) begin
            count_o <= count_o + 7'h01;
        end else if (do_rd && !do_wr) begin
            count_o <= count_o - 7'h01;
        end
    end
endmodule // fifo_ring

/* File: hw/host_fifo_interface.sv */
// host side of the reader: parallel and serial framing, register file
// and the transmit/receive byte store.
// assumes data_clk_i and io_i come from the host, unsynchronised, and
// the protocol engine runs on clk_i.

// Summary of operation
// - 127-byte circular store at 0x1F
// - command 0x0F empties store, zeroes count
// - 0x1C low seven bits give occupancy
// - 12-bit byte count plus 4-bit remainder
// - watch almost-empty on transmit, almost-full receive
// - watermark crossing from 0x14 sets flag
// - data7 rising, clock high: start, reset
// - data7 falling, clock high: simple stop
// - rise then fall, clock low: continuous stop
// - receive start-of-frame sets status bit 6
// - short frame: complete only; long: level too
// - receive errors set framing or CRC flag
// - length bytes split into nibbles
// - first stored byte starts transmission
// - transmit start sets bit 7, end interrupts
// - straps sampled once choose interface mode
// - word: command, read, continuous, code
// - continuous mode increments address per byte, except at 0x1F
// - slave select high holds serial reset
module host_fifo_interface (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic data_clk_i,
    input wire logic [7:0] io_i,
    output logic [7:0] io_o,
    output logic [7:0] io_oe_o,
    output logic irq_o,
    output logic [4:0] cmd_o,
    output logic cmd_valid_o,
    output logic [7:0] tx_byte_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output logic tx_start_o,
    output logic [11:0] tx_len_o,
    output logic [3:0] tx_bits_o,
    input wire logic tx_done_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    input wire logic rx_sof_i,
    input wire logic rx_end_i,
    input wire logic rx_frame_err_i,
    input wire logic rx_crc_err_i
);
    // ----------------------------------------------------------------
    // pin synchronisers and edges
    // ----------------------------------------------------------------
    logic [8:0] pin_meta;
    logic [8:0] pin_sync;
    logic [8:0] pin_last;
    always_ff @(posedge clk_i) begin
        pin_meta <= {data_clk_i, io_i};
        pin_sync <= pin_meta;
        pin_last <= pin_sync;
    end

    logic clk_hi;
    logic clk_lo;
    logic clk_rise;
    logic clk_fall;
    logic d7_rise;
    logic d7_fall;
    assign clk_hi = pin_sync[8] & pin_last[8];
    assign clk_lo = ~pin_sync[8] & ~pin_last[8];
    assign clk_rise = pin_sync[8] & ~pin_last[8];
    assign clk_fall = ~pin_sync[8] & pin_last[8];
    assign d7_rise = pin_sync[host_if_pkg::PIN_START] & ~pin_last[host_if_pkg::PIN_START];
    assign d7_fall = ~pin_sync[host_if_pkg::PIN_START] & pin_last[host_if_pkg::PIN_START];

    // ----------------------------------------------------------------
    // interface mode from straps
    // ----------------------------------------------------------------
    host_if_pkg::mode_e mode;
    logic strap_done;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            strap_done <= 1'b0;
            mode <= host_if_pkg::MODE_PAR;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            case (pin_sync[2:0])
                host_if_pkg::STRAP_SPI_SS: mode <= host_if_pkg::MODE_SPI_SS;
                host_if_pkg::STRAP_SPI_NOSS: mode <= host_if_pkg::MODE_SPI_NOSS;
                default: mode <= host_if_pkg::MODE_PAR;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // framing conditions
    // ----------------------------------------------------------------
    logic use_ss;
    logic serial;
    logic ss_n;
    logic ss_rise;
    logic start_cond;
    logic simple_stop;
    logic cont_armed;
    logic continuous_stop;
    logic frame_end;
    logic frame_reset;
    logic active;
    assign use_ss = mode == host_if_pkg::MODE_SPI_SS;
    assign serial = mode != host_if_pkg::MODE_PAR;
    assign ss_n = pin_sync[host_if_pkg::PIN_SS];
    assign ss_rise = use_ss & ss_n & ~pin_last[host_if_pkg::PIN_SS];
    assign start_cond = strap_done & ~use_ss & clk_hi & d7_rise;
    assign simple_stop = strap_done & ~use_ss & clk_hi & d7_fall;
    assign continuous_stop = ~use_ss & cont_armed & clk_lo & d7_fall;
    assign frame_end = simple_stop | continuous_stop | ss_rise;
    assign frame_reset = start_cond | frame_end | (use_ss & ss_n);

    // a rise while the clock is low arms the continuous stop
    always_ff @(posedge clk_i) begin
        if (srst_i || !clk_lo) begin
            cont_armed <= 1'b0;
        end else if (d7_rise) begin
            cont_armed <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            active <= 1'b0;
        end else if (use_ss) begin
            active <= ~ss_n & strap_done;
        end else if (start_cond) begin
            active <= 1'b1;
        end else if (frame_end) begin
            active <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // byte assembly: serial on falling clock, parallel on rising
    // ----------------------------------------------------------------
    logic [6:0] in_sh;
    logic [2:0] bit_cnt;
    logic byte_stb;
    logic [7:0] byte_val;
    assign byte_stb = active & !frame_reset &
        (serial ? (clk_fall & bit_cnt == host_if_pkg::BIT_LAST) : clk_rise);
    assign byte_val = serial ? {in_sh, pin_sync[host_if_pkg::PIN_MOSI]} : pin_sync[7:0];

    always_ff @(posedge clk_i) begin
        if (srst_i || frame_reset) begin
            bit_cnt <= 3'h0;
            in_sh <= 7'h00;
        end else if (active && serial && clk_fall) begin
            bit_cnt <= bit_cnt + 3'h1;
            in_sh <= {in_sh[5:0], pin_sync[host_if_pkg::PIN_MOSI]};
        end
    end

    // ----------------------------------------------------------------
    // word decoding and address sequencing
    // ----------------------------------------------------------------
    host_if_pkg::phase_e phase;
    logic [4:0] addr;
    logic rd_mode;
    logic cont;
    logic [4:0] addr_adv;
    logic [4:0] rd_addr;
    logic read_stb;
    logic write_stb;
    logic is_cmd;
    // the data port keeps its address so a stream fills the store
    assign addr_adv = (addr == host_if_pkg::REG_FIFO_DATA) ? addr : addr + 5'h01;
    assign is_cmd = byte_val[host_if_pkg::WB_CMD];
    assign rd_addr = (phase == host_if_pkg::PH_ADDR) ? byte_val[4:0] : addr_adv;
    assign read_stb = byte_stb & ((phase == host_if_pkg::PH_ADDR & ~is_cmd &
        byte_val[host_if_pkg::WB_READ]) | (phase == host_if_pkg::PH_DATA & rd_mode & cont));
    assign write_stb = byte_stb & phase == host_if_pkg::PH_DATA & ~rd_mode;

    always_ff @(posedge clk_i) begin
        if (srst_i || frame_reset) begin
            phase <= host_if_pkg::PH_ADDR;
            addr <= 5'h00;
            rd_mode <= 1'b0;
            cont <= 1'b0;
        end else if (byte_stb) begin
            case (phase)
                host_if_pkg::PH_ADDR: begin
                    if (!is_cmd) begin
                        phase <= host_if_pkg::PH_DATA;
                        addr <= byte_val[4:0];
                        rd_mode <= byte_val[host_if_pkg::WB_READ];
                        cont <= byte_val[host_if_pkg::WB_CONT];
                    end
                end
                host_if_pkg::PH_DATA: begin
                    if (cont) begin
                        addr <= addr_adv;
                    end else begin
                        phase <= host_if_pkg::PH_IGNORE;
                    end
                end
                default: phase <= host_if_pkg::PH_IGNORE;
            endcase
        end
    end

    logic fifo_clear;
    assign fifo_clear = byte_stb & phase == host_if_pkg::PH_ADDR & is_cmd &
        byte_val[4:0] == host_if_pkg::CMD_FIFO_RESET;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cmd_valid_o <= 1'b0;
            cmd_o <= 5'h00;
        end else begin
            cmd_valid_o <= byte_stb & phase == host_if_pkg::PH_ADDR & is_cmd;
            if (byte_stb && phase == host_if_pkg::PH_ADDR && is_cmd) begin
                cmd_o <= byte_val[4:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // byte store and its two users
    // ----------------------------------------------------------------
    logic f_wr_ready;
    logic f_rd_valid;
    logic f_rd_ready;
    logic [7:0] f_rd_data;
    logic [host_if_pkg::CNT_W-1:0] f_count;
    logic host_push;
    logic host_pop;
    logic rx_active;
    logic tx_active;
    assign host_push = write_stb & addr == host_if_pkg::REG_FIFO_DATA;
    assign host_pop = read_stb & rd_addr == host_if_pkg::REG_FIFO_DATA & f_rd_valid;
    assign rx_ready_o = rx_active & ~host_push & f_wr_ready;
    assign tx_valid_o = tx_active & f_rd_valid & ~host_pop;
    assign tx_byte_o = f_rd_data;
    assign f_rd_ready = host_pop | (tx_valid_o & tx_ready_i);

    fifo_ring store (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .clear_i(fifo_clear),
        .wr_valid_i(host_push | (rx_active & rx_valid_i)),
        .wr_data_i(host_push ? byte_val : rx_byte_i),
        .wr_ready_o(f_wr_ready),
        .rd_valid_o(f_rd_valid),
        .rd_ready_i(f_rd_ready),
        .rd_data_o(f_rd_data),
        .count_o(f_count)
    );

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] irq_status;
    logic [7:0] coll_mask;
    logic [7:0] watermark;
    logic [7:0] tx_len_hi;
    logic [7:0] tx_len_lo;
    logic tx_armed;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            coll_mask <= 8'h00;
            watermark <= host_if_pkg::WATERMARK_RESET;
            tx_len_hi <= 8'h00;
            tx_len_lo <= 8'h00;
        end else if (write_stb) begin
            case (addr)
                host_if_pkg::REG_COLL_MASK: coll_mask <= byte_val;
                host_if_pkg::REG_WATERMARK: watermark <= byte_val;
                host_if_pkg::REG_TX_LEN_HI: tx_len_hi <= byte_val;
                host_if_pkg::REG_TX_LEN_LO: tx_len_lo <= byte_val;
                default: ;
            endcase
        end
    end
    assign tx_len_o = {tx_len_hi, tx_len_lo[7:4]};
    assign tx_bits_o = tx_len_lo[3:0];

    // ----------------------------------------------------------------
    // transmit and receive activity
    // ----------------------------------------------------------------
    logic tx_go;
    assign tx_go = host_push & tx_armed & ~tx_active;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_armed <= 1'b0;
            tx_active <= 1'b0;
            tx_start_o <= 1'b0;
            rx_active <= 1'b0;
        end else begin
            tx_start_o <= tx_go;
            if (write_stb && addr == host_if_pkg::REG_TX_LEN_LO) begin
                tx_armed <= 1'b1;
            end else if (tx_go) begin
                tx_armed <= 1'b0;
            end
            if (tx_go) begin
                tx_active <= 1'b1;
            end else if (tx_done_i) begin
                tx_active <= 1'b0;
            end
            if (rx_sof_i) begin
                rx_active <= 1'b1;
            end else if (rx_end_i) begin
                rx_active <= 1'b0;
            end
        end
    end

    // almost-empty while sending, almost-full while receiving
    logic [6:0] rx_level;
    logic [6:0] tx_level;
    logic wm_hit;
    logic wm_last;
    assign rx_level = RX_SLICE(watermark[host_if_pkg::WM_RX_LSB +: 2]);
    assign tx_level = TX_SLICE(watermark[host_if_pkg::WM_TX_LSB +: 2]);
    assign wm_hit = tx_active ? (f_count <= tx_level) :
        (rx_active & f_count >= rx_level);

    function automatic logic [6:0] RX_SLICE(input logic [1:0] sel);
        return host_if_pkg::RX_LEVELS[7 * sel +: 7];
    endfunction
    function automatic logic [6:0] TX_SLICE(input logic [1:0] sel);
        return host_if_pkg::TX_LEVELS[7 * sel +: 7];
    endfunction

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wm_last <= 1'b0;
        end else begin
            wm_last <= wm_hit;
        end
    end

    // ----------------------------------------------------------------
    // status flags; a set in the clearing cycle survives
    // ----------------------------------------------------------------
    logic clr_pend;
    logic clr_now;
    logic [7:0] sets;
    always_comb begin
        sets = 8'h00;
        sets[host_if_pkg::IRQ_TX] = tx_go | tx_done_i;
        sets[host_if_pkg::IRQ_RX] = rx_sof_i | rx_end_i;
        sets[host_if_pkg::IRQ_FIFO] = wm_hit & ~wm_last;
        sets[host_if_pkg::IRQ_CRC] = rx_crc_err_i;
        sets[host_if_pkg::IRQ_FRAME] = rx_frame_err_i;
    end

    // the clear lands one byte after the status read, or at the stop
    assign clr_now = clr_pend & (byte_stb | frame_end);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            clr_pend <= 1'b0;
        end else if (read_stb && rd_addr == host_if_pkg::REG_IRQ_STATUS) begin
            clr_pend <= 1'b1;
        end else if (clr_now) begin
            clr_pend <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_status <= 8'h00;
        end else begin
            irq_status <= (clr_now ? 8'h00 : irq_status) | sets;
        end
    end

    // start flags stay quiet on the pin until their operation ends
    assign irq_o = |(irq_status & ~{tx_active, rx_active, 6'h00});

    // ----------------------------------------------------------------
    // read data path
    // ----------------------------------------------------------------
    logic [7:0] rd_val;
    logic [7:0] out_sh;
    always_comb begin
        case (rd_addr)
            host_if_pkg::REG_IRQ_STATUS: rd_val = irq_status;
            host_if_pkg::REG_COLL_MASK: rd_val = coll_mask;
            host_if_pkg::REG_WATERMARK: rd_val = watermark;
            host_if_pkg::REG_FIFO_OCC: rd_val = {wm_hit, f_count};
            host_if_pkg::REG_TX_LEN_HI: rd_val = tx_len_hi;
            host_if_pkg::REG_TX_LEN_LO: rd_val = tx_len_lo;
            host_if_pkg::REG_FIFO_DATA: rd_val = f_rd_valid ? f_rd_data : 8'h00;
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || frame_reset) begin
            out_sh <= 8'h00;
        end else if (read_stb) begin
            out_sh <= rd_val;
        end else if (active && serial && clk_fall) begin
            out_sh <= {out_sh[6:0], 1'b0};
        end
    end

    // parallel reads drive the bus only while the clock is low
    logic reading;
    assign reading = active & rd_mode & phase == host_if_pkg::PH_DATA;
    always_comb begin
        io_o = 8'h00;
        io_oe_o = 8'h00;
        if (serial) begin
            io_o[host_if_pkg::PIN_MISO] = out_sh[7];
            io_oe_o[host_if_pkg::PIN_MISO] = reading;
        end else if (reading && clk_lo) begin
            io_o = out_sh;
            io_oe_o = 8'hFF;
        end
    end
endmodule // host_fifo_interface

/* File: include/host_if_pkg.sv */
// constants of the reader host interface: register map, word layout,
// status bits, strap codes and watermark tables.
// assumes nothing of its surroundings.
package host_if_pkg;
    localparam int FIFO_DEPTH = 127;
    localparam int CNT_W = 7;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [4:0] REG_IRQ_STATUS = 5'h0C;
    localparam logic [4:0] REG_COLL_MASK = 5'h0D;
    localparam logic [4:0] REG_WATERMARK = 5'h14;
    localparam logic [4:0] REG_FIFO_OCC = 5'h1C;
    localparam logic [4:0] REG_TX_LEN_HI = 5'h1D;
    localparam logic [4:0] REG_TX_LEN_LO = 5'h1E;
    localparam logic [4:0] REG_FIFO_DATA = 5'h1F;
    localparam logic [4:0] CMD_FIFO_RESET = 5'h0F;

    // ----------------------------------------------------------------
    // host word layout and status bits
    // ----------------------------------------------------------------
    localparam int WB_CMD = 7;
    localparam int WB_READ = 6;
    localparam int WB_CONT = 5;
    localparam int IRQ_TX = 7;
    localparam int IRQ_RX = 6;
    localparam int IRQ_FIFO = 5;
    localparam int IRQ_CRC = 4;
    localparam int IRQ_FRAME = 2;
    localparam int OCC_WM = 7;

    // ----------------------------------------------------------------
    // pins and straps
    // ----------------------------------------------------------------
    localparam int PIN_MOSI = 7;
    localparam int PIN_MISO = 6;
    localparam int PIN_SS = 4;
    localparam int PIN_START = 7;
    localparam logic [2:0] STRAP_SPI_SS = 3'h6;
    localparam logic [2:0] STRAP_SPI_NOSS = 3'h4;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // ----------------------------------------------------------------
    // watermark tables, 7 bits per entry, entry 0 is the reset choice
    // ----------------------------------------------------------------
    localparam logic [7:0] WATERMARK_RESET = 8'h00;
    localparam int WM_RX_LSB = 2;
    localparam int WM_TX_LSB = 0;
    localparam logic [27:0] RX_LEVELS = {7'h60, 7'h70, 7'h78, 7'h7C};
    localparam logic [27:0] TX_LEVELS = {7'h20, 7'h10, 7'h08, 7'h04};

    typedef enum logic [1:0] {MODE_PAR, MODE_SPI_SS, MODE_SPI_NOSS} mode_e;
    typedef enum logic [1:0] {PH_ADDR, PH_DATA, PH_IGNORE} phase_e;
endpackage

/* File: sim/host_fifo_chk.sv */
// port-level checks of the reader host interface.
// assumes the bench drives host pins and the codec-side strobes.
module host_fifo_chk (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic data_clk_i,
    input wire logic [7:0] io_oe_o,
    input wire logic irq_o,
    input wire logic [4:0] cmd_o,
    input wire logic cmd_valid_o,
    input wire logic [7:0] tx_byte_o,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic tx_start_o,
    input wire logic [11:0] tx_len_o,
    input wire logic [3:0] tx_bits_o,
    input wire logic tx_done_i,
    input wire logic rx_valid_i,
    input wire logic rx_ready_o,
    input wire logic rx_crc_err_i
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    reset_quiet_a: assert property (disable iff (1'b0)
        srst_i |=> !irq_o && !tx_start_o && io_oe_o == 8'h00)
        else $error("outputs active after reset");
    start_pulse_a: assert property (tx_start_o |=> !tx_start_o)
        else $error("transmit start longer than one cycle");
    cmd_pulse_a: assert property (cmd_valid_o |=> !cmd_valid_o)
        else $error("command strobe longer than one cycle");
    oe_shape_a: assert property (io_oe_o inside {8'h00, 8'h40, 8'hFF})
        else $error("pin drive pattern unexpected");
    // registers may only move after host clock activity
    regs_idle_a: assert property ($stable(data_clk_i) [*6] |=>
        $stable(tx_len_o) && $stable(tx_bits_o) && $stable(cmd_o))
        else $error("registers changed with host idle");
    start_valid_a: assert property (tx_start_o |-> ##[0:2] tx_valid_o)
        else $error("transmit start without data offered");
    tx_hold_a: assert property (($stable(data_clk_i) && !tx_done_i) [*6]
        ##0 (tx_valid_o && !tx_ready_i) |=> tx_valid_o && $stable(tx_byte_o))
        else $error("stalled transmit byte not held");
    crc_irq_a: assert property (rx_crc_err_i |-> ##[1:2] irq_o)
        else $error("crc error without request");
    cover property (tx_start_o);
    cover property (cmd_valid_o);
    cover property (rx_valid_i && rx_ready_o);
endmodule // host_fifo_chk

bind host_fifo_interface host_fifo_chk u_chk (.clk_i, .srst_i, .data_clk_i, .io_oe_o,
    .irq_o, .cmd_o, .cmd_valid_o, .tx_byte_o, .tx_valid_o, .tx_ready_i, .tx_start_o,
    .tx_len_o, .tx_bits_o, .tx_done_i, .rx_valid_i, .rx_ready_o, .rx_crc_err_i);

/* File: sim/host_fifo_interface_tb.sv */
// self-checking bench of the host interface in serial mode.
// assumes the host model and the port checker are compiled alongside.
module host_fifo_interface_tb;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
    logic clk_i = 1'b0, srst_i = 1'b1, data_clk_i, tx_ready_i = 1'b0, tx_done_i = 1'b0;
    logic rx_valid_i = 1'b0, rx_sof_i = 1'b0, rx_end_i = 1'b0;
    logic rx_frame_err_i = 1'b0, rx_crc_err_i = 1'b0;
    logic [7:0] io_i, io_o, io_oe_o, mcu_io, tx_byte_o, rx_byte_i = 8'h00, d, x;
    logic irq_o, cmd_valid_o, tx_valid_o, tx_start_o, rx_ready_o;
    logic [4:0] cmd_o;
    logic [11:0] tx_len_o;
    logic [3:0] tx_bits_o;
    int err_count = 0, samples_checked = 0;
    always #50 clk_i = ~clk_i;
    assign io_i = (io_oe_o & io_o) | (~io_oe_o & mcu_io);
    mcu_model u_mcu (.data_clk_o(data_clk_i), .io_o(mcu_io), .io_i(io_i));
    host_fifo_interface dut (.clk_i, .srst_i, .data_clk_i, .io_i, .io_o, .io_oe_o, .irq_o,
        .cmd_o, .cmd_valid_o, .tx_byte_o, .tx_valid_o, .tx_ready_i, .tx_start_o, .tx_len_o,
        .tx_bits_o, .tx_done_i, .rx_byte_i, .rx_valid_i, .rx_ready_o, .rx_sof_i, .rx_end_i,
        .rx_frame_err_i, .rx_crc_err_i);
    task automatic send(input logic [7:0] q[$]);
        u_mcu.sel();
        foreach (q[i]) u_mcu.xfer(q[i], x);
        u_mcu.desel();
    endtask
    task automatic rd(input logic [7:0] w, output logic [7:0] v);
        u_mcu.sel();
        u_mcu.xfer(w, x);
        u_mcu.xfer(8'h00, v);
        u_mcu.desel();
    endtask
    task automatic clr(output logic [7:0] v);
        u_mcu.sel();
        u_mcu.xfer(8'h6C, x);
        u_mcu.xfer(8'h00, v);
        u_mcu.xfer(8'h00, x);
        u_mcu.desel();
    endtask
    // one-hot event select: done, sof, end, crc, frame
    task automatic pulse(input logic [4:0] m);
        @(posedge clk_i) {tx_done_i, rx_sof_i, rx_end_i, rx_crc_err_i, rx_frame_err_i} <= m;
        @(posedge clk_i) {tx_done_i, rx_sof_i, rx_end_i, rx_crc_err_i, rx_frame_err_i} <= 5'h00;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic take(input logic [7:0] e);
        int n = 0;
        @(negedge clk_i);
        while (tx_valid_o !== 1'b1 && n < 50) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 50) begin
            err_count++;
            close_out();
        end
        `CHK(tx_byte_o, e)
        @(posedge clk_i) tx_ready_i <= 1'b1;
        @(posedge clk_i) tx_ready_i <= 1'b0;
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(8'h54, d);
        `CHK(d, host_if_pkg::WATERMARK_RESET)
        send('{8'h14, 8'h05});
        rd(8'h54, d);
        `CHK(d, 8'h05)
        rd(8'h5F, d);
        `CHK(d, 8'h00)
        send('{8'h8F});
        `CHK(cmd_o, host_if_pkg::CMD_FIFO_RESET)
        // transmit: length 3 bytes plus 2 bits, encoder stalled meanwhile
        send('{8'h3D, 8'h00, 8'h32, 8'hA1, 8'hA2, 8'hA3});
        `CHK({tx_len_o, tx_bits_o}, 16'h0032)
        rd(8'h5C, d);
        `CHK(d, 8'h83)
        for (int i = 0; i < 3; i++) take(8'hA1 + i[7:0]);
        pulse(5'h10);
        `CHK(irq_o, 1'b1)
        clr(d);
        `CHK(d[7], 1'b1)
        `CHK(irq_o, 1'b0)
        // receive five bytes, pop four while reading back three, then clear the store
        pulse(5'h08);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_i) rx_byte_i <= 8'h10 + i[7:0];
            rx_valid_i <= 1'b1;
            @(negedge clk_i) `CHK(rx_ready_o, 1'b1)
            @(posedge clk_i) rx_valid_i <= 1'b0;
        end
        pulse(5'h04);
        `CHK(irq_o, 1'b1)
        clr(d);
        `CHK(d[6], 1'b1)
        rd(8'h5C, d);
        `CHK(d, 8'h05)
        u_mcu.sel();
        u_mcu.xfer(8'h7F, x);
        for (int i = 0; i < 3; i++) begin
            u_mcu.xfer(8'h00, d);
            `CHK(d, 8'h10 + i[7:0])
        end
        u_mcu.desel();
        send('{8'h8F});
        rd(8'h5C, d);
        `CHK(d, 8'h00)
        pulse(5'h02);
        pulse(5'h01);
        clr(d);
        `CHK({d[4], d[2]}, 2'b11)
        close_out();
    end
endmodule // host_fifo_interface_tb

/* File: sim/mcu_model.sv */
// host microcontroller model: serial master with slave select.
// assumes the bench resolves the pins shared with the device.
module mcu_model (
    output logic data_clk_o,
    output logic [7:0] io_o,
    input wire logic [7:0] io_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ss_n = 1'b1;
    logic mosi = 1'b0;
    logic junk = 1'b0;
    // released return line floats: keep it flipping so no stale bit passes
    assign io_o = {mosi, junk, 1'b0, ss_n, 1'b0, host_if_pkg::STRAP_SPI_SS};
    initial data_clk_o = 1'b0;
    task automatic sel();
        #137 ss_n = 1'b0;
        #400;
    endtask
    task automatic desel();
        #400 ss_n = 1'b1;
        #800;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            data_clk_o = 1'b1;
            mosi = tx[i];
            junk = ~junk;
            #400 rx[i] = io_i[host_if_pkg::PIN_MISO];
            data_clk_o = 1'b0;
            #400;
        end
    endtask
endmodule // mcu_model
